// >>> logic/ppm_caps_reg.sv
// Read-only power capabilities word of one host function.
// Assumes a bus-side read port with byte-granular configuration offset.
`timescale 1ns/10ps
module ppm_caps_reg
   import ppm_pkg::*;
#(
   parameter ppm_fn_kind_t FN_KIND       = PPM_FN_HIGH,
   parameter logic         HAS_DATA_REG  = 1'b0,
   parameter logic [2:0]   AUX_CODE      = PPM_AUX_RESET,
   parameter logic         NEEDS_DEV_INIT = 1'b0,
   parameter logic         WAKE_CLK_DEP  = 1'b0
)(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       amber_led4_strap,
   input  wire logic       cfg_rd,
   input  wire logic       cfg_wr,
   input  wire logic [7:0] cfg_addr,
   input  wire logic [15:0] cfg_wdata,
   output logic [15:0]     cfg_rdata,
   output logic            cfg_hit,
   output logic [15:0]     power_capabilities
);

   // ==================================================================
   // Strap capture
   logic strap_sync;
   logic strap_taken_r;
   logic wake_cold_r;
   logic wake_cold_nxt;

   ppm_strap_sync u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pin_in   (amber_led4_strap),
      .pin_sync (strap_sync)
   );

   // The strap is latched once, after the synchroniser has filled.
   logic [1:0] settle_r;
   assign wake_cold_nxt = (settle_r == 2'h2 && !strap_taken_r) ? strap_sync : wake_cold_r;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         settle_r      <= 2'h0;
         strap_taken_r <= 1'b0;
         wake_cold_r   <= 1'b0;
      end else begin
         if (settle_r != 2'h2) begin
            settle_r <= settle_r + 2'h1;
         end
         if (settle_r == 2'h2) begin
            strap_taken_r <= 1'b1;
         end
         wake_cold_r <= wake_cold_nxt;
      end
   end

   // ==================================================================
   // Word assembly
   wire logic       variant     = (FN_KIND == PPM_FN_HIGH);
   wire logic [4:0] wake_vec    = PPM_WAKE_FIXED | (variant ? PPM_WAKE_VARIANT : 5'h00)
                                  | {wake_cold_r, 4'h0};
   wire logic       any_wake    = |wake_vec;
   wire logic [2:0] aux_val     = (HAS_DATA_REG || !wake_cold_r) ? PPM_AUX_NONE
                                                                 : AUX_CODE;
   ppm_caps_t caps;

   assign caps.wake_state_support   = wake_vec;
   assign caps.d2_support           = variant;
   assign caps.d1_support           = PPM_D1_FIXED;
   assign caps.aux_current          = aux_val;
   assign caps.dev_init             = NEEDS_DEV_INIT;
   assign caps.reserved4            = 1'b0;
   assign caps.wake_needs_bus_clock = WAKE_CLK_DEP & any_wake;
   assign caps.pm_spec_version      = PPM_VERSION_1P1;

   wire logic addr_hit = (cfg_addr == PPM_CAPS_OFFSET);
   wire logic read_hit = cfg_rd && addr_hit;

   // Writes are not decoded at all; the word is constant apart from the strap.
   wire logic unused_wr = cfg_wr ^ (^cfg_wdata);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cfg_rdata          <= 16'h0000;
         cfg_hit            <= 1'b0;
         power_capabilities <= 16'h0000;
      end else begin
         power_capabilities <= caps;
         cfg_hit            <= read_hit;
         cfg_rdata          <= read_hit ? caps : 16'h0000;
      end
   end

   // ==================================================================
   // Checks
   // Named steps of a read and of the strap capture.
   sequence s_strap_done;
      strap_taken_r;
   endsequence

   sequence s_read_taken;
      cfg_rd && addr_hit;
   endsequence

   sequence s_read_missed;
      cfg_rd && !addr_hit;
   endsequence

   sequence s_read_idle;
      !cfg_rd;
   endsequence

   sequence s_word_settled;
      $past(strap_taken_r, 2);
   endsequence

   sequence s_in_reset;
      !rst_n;
   endsequence

   sequence s_first_run;
      $past(rst_n) && !strap_taken_r;
   endsequence

   a_aux_zero_nowake: assert property (@(posedge core_clk) disable iff (!rst_n)
      !power_capabilities[15] |-> power_capabilities[8:6] == 3'h0)
      else $error("aux current nonzero without cold wake");
   a_data_reg_aux: assert property (@(posedge core_clk) disable iff (!rst_n)
      HAS_DATA_REG |-> power_capabilities[8:6] == 3'h0)
      else $error("aux current nonzero with data register");
   a_version_read: assert property (@(posedge core_clk) disable iff (!rst_n)
      cfg_rd && addr_hit |=> cfg_hit && cfg_rdata[2:0] == 3'h2)
      else $error("version field wrong on read");
   a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      cfg_hit |-> cfg_rdata[4] == 1'b0)
      else $error("reserved bit set");
   a_strap_stable: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_strap_done |=> $stable(wake_cold_r))
      else $error("strap value changed after capture");
   a_strap_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
      settle_r == 2'h2 && !strap_taken_r |=> wake_cold_r == $past(strap_sync) ##1
      power_capabilities[15] == wake_cold_r)
      else $error("strap not captured into bit 15");
   a_wake_variant: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(rst_n) |-> power_capabilities[13] == variant && power_capabilities[11] == variant
      && power_capabilities[10] == variant)
      else $error("variant bits wrong");
   a_pmeclk_nowake: assert property (@(posedge core_clk) disable iff (!rst_n)
      power_capabilities[15:11] == 5'h00 |-> !power_capabilities[3])
      else $error("clock flag set without wake support");
   a_dsi_value: assert property (@(posedge core_clk) disable iff (!rst_n)
      cfg_hit |-> cfg_rdata[5] == NEEDS_DEV_INIT)
      else $error("device init flag wrong");
   a_aux_code: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(rst_n) && power_capabilities[15] && !HAS_DATA_REG
      |-> power_capabilities[8:6] == AUX_CODE)
      else $error("aux code wrong");

   // ==================================================================
   // Read port checks
   // A hit answers on the next edge with the same word that the mirror output carries.
   a_read_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_read_taken |=> cfg_hit && cfg_rdata == power_capabilities)
      else $error("read hit did not return the word");
   a_read_single: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_read_taken ##1 s_read_idle |=> !cfg_hit && cfg_rdata == 16'h0000)
      else $error("read answer held past one cycle");
   a_read_miss: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_read_missed |=> !cfg_hit && cfg_rdata == 16'h0000)
      else $error("missed address answered");
   a_hit_source: assert property (@(posedge core_clk) disable iff (!rst_n)
      cfg_hit |-> $past(cfg_rd) && $past(addr_hit))
      else $error("hit without a matching read");

   // ==================================================================
   // Word content checks
   // Every field of the mirror word but the cold wake bit and aux current follows its setting from the second edge after reset.
   a_fixed_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(rst_n) |-> power_capabilities[14] && power_capabilities[12])
      else $error("fixed wake support bits clear");
   a_d1_fixed: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(rst_n) |-> power_capabilities[9] == PPM_D1_FIXED)
      else $error("D1 support bit wrong");
   a_pmeclk_value: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(rst_n) |-> power_capabilities[3] == (WAKE_CLK_DEP && |power_capabilities[15:11]))
      else $error("clock flag does not follow its setting");
   a_dsi_word: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(rst_n) |-> power_capabilities[5] == NEEDS_DEV_INIT)
      else $error("device init flag wrong in word");
   a_version_word: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(rst_n) |-> power_capabilities[2:0] == PPM_VERSION_1P1)
      else $error("version field wrong in word");
   a_reserved_word: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(rst_n) |-> !power_capabilities[4])
      else $error("reserved bit set in word");
   a_aux_read: assert property (@(posedge core_clk) disable iff (!rst_n)
      cfg_hit && !cfg_rdata[15] |-> cfg_rdata[8:6] == PPM_AUX_NONE)
      else $error("aux current read nonzero without cold wake");
   a_aux_read_dreg: assert property (@(posedge core_clk) disable iff (!rst_n)
      cfg_hit && HAS_DATA_REG |-> cfg_rdata[8:6] == PPM_AUX_NONE)
      else $error("aux current read nonzero with data register");
   a_variant_read: assert property (@(posedge core_clk) disable iff (!rst_n)
      cfg_hit |-> cfg_rdata[13] == variant && cfg_rdata[11] == variant && cfg_rdata[10] == variant)
      else $error("variant bits wrong on read");

   // ==================================================================
   // Strap and write checks
   // Once the strap is in, nothing but a new reset may change the word.
   a_strap_pending: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_first_run |-> !wake_cold_r && !power_capabilities[15])
      else $error("cold wake bit set before strap capture");
   a_cold_read: assert property (@(posedge core_clk) disable iff (!rst_n)
      cfg_hit |-> cfg_rdata[15] == $past(wake_cold_r))
      else $error("cold wake bit on read differs from captured strap");
   a_caps_frozen: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_word_settled |-> $stable(power_capabilities))
      else $error("word changed after strap capture");
   a_write_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_word_settled ##0 cfg_wr |=> $stable(power_capabilities))
      else $error("write disturbed the word");
   a_reset_clear: assert property (@(posedge core_clk)
      s_in_reset |=> power_capabilities == 16'h0000 && !cfg_hit && cfg_rdata == 16'h0000)
      else $error("outputs not cleared by reset");

endmodule

// >>> logic/ppm_pkg.sv
// Constants, field layout and carrier types for the power capabilities word.
// Assumes one instance per host function, read through a configuration read port.
package ppm_pkg;

   // ==================================================================
   // Field positions
   localparam int PPM_WAKE_LSB    = 11;
   localparam int PPM_D2_BIT      = 10;
   localparam int PPM_D1_BIT      = 9;
   localparam int PPM_AUX_LSB     = 6;
   localparam int PPM_DSI_BIT     = 5;
   localparam int PPM_RSVD_BIT    = 4;
   localparam int PPM_PMECLK_BIT  = 3;
   localparam int PPM_VER_LSB     = 0;

   // ==================================================================
   // Values and offsets
   localparam logic [7:0] PPM_CAP_PTR      = 8'h34;
   localparam logic [7:0] PPM_CAPS_OFFSET  = 8'h36;
   localparam logic [2:0] PPM_VERSION_1P1  = 3'h2;
   localparam logic [2:0] PPM_AUX_NONE     = 3'h0;
   localparam logic [2:0] PPM_AUX_RESET    = 3'h2;
   localparam logic [4:0] PPM_WAKE_FIXED   = 5'h0A;
   localparam logic [4:0] PPM_WAKE_VARIANT = 5'h05;
   localparam logic       PPM_D1_FIXED     = 1'b1;

   // ==================================================================
   // Carriers
   typedef enum logic [1:0] {
      PPM_FN_FULL_LOW = 2'h1,
      PPM_FN_HIGH     = 2'h2
   } ppm_fn_kind_t;

   typedef struct packed {
      logic [4:0] wake_state_support;
      logic       d2_support;
      logic       d1_support;
      logic [2:0] aux_current;
      logic       dev_init;
      logic       reserved4;
      logic       wake_needs_bus_clock;
      logic [2:0] pm_spec_version;
   } ppm_caps_t;

endpackage

// >>> logic/ppm_strap_sync.sv
// Two-stage synchroniser for the strap pin.
// Assumes the pin is static around power-on.
`timescale 1ns/10ps
module ppm_strap_sync
   import ppm_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic pin_in,
   output logic      pin_sync
);

   logic meta_r;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         meta_r   <= 1'b0;
         pin_sync <= 1'b0;
      end else begin
         meta_r   <= pin_in;
         pin_sync <= meta_r;
      end
   end

endmodule

// >>> verification/pci_pm_capability_lower_fields_tb.sv
// Self-checking bench for the power capabilities word, two function variants.
// Assumes the host bridge model in ppm_host_bridge drives the read port.
`timescale 1ns/10ps
module pci_pm_capability_lower_fields_tb;
   import ppm_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic strap = 1'b1;
   logic cfg_rd, cfg_wr, hit_a, hit_b;
   logic [7:0] cfg_addr;
   logic [15:0] cfg_wdata, rdata_a, caps_a, rdata_b, caps_b;
   int num_errors = 0;
   int compares = 0;
   always #20 core_clk = ~core_clk;
   ppm_host_bridge u_host (.core_clk(core_clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata));
   ppm_caps_reg u_dut (.core_clk(core_clk), .rst_n(rst_n), .amber_led4_strap(strap),
      .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
      .cfg_rdata(rdata_a), .cfg_hit(hit_a), .power_capabilities(caps_a));
   ppm_caps_reg #(.FN_KIND(PPM_FN_FULL_LOW), .HAS_DATA_REG(1'b1), .AUX_CODE(3'h5),
      .NEEDS_DEV_INIT(1'b1), .WAKE_CLK_DEP(1'b1)) u_dut_b (.core_clk(core_clk),
      .rst_n(rst_n), .amber_led4_strap(strap), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(rdata_b),
      .cfg_hit(hit_b), .power_capabilities(caps_b));
   // ==================================================================
   // Reference model of the word.
   function automatic logic [15:0] model(int hi, int dreg, int aux, int dsi, int ck, int s);
      int w;
      w = (s << 15) | (1 << 14) | (hi << 13) | (1 << 12) | (hi << 11) | (hi << 10) | (1 << 9);
      w = w | (((dreg != 0) || (s == 0)) ? 0 : aux) << 6;
      w = w | (dsi << 5) | (ck << 3) | 2;
      return w[15:0];
   endfunction
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ==================================================================
   // Both strap levels, reads, ignored writes and missed addresses.
   initial begin
      logic [15:0] ea, eb;
      void'($urandom(32'h4cb2));
      for (int s = 1; s >= 0; s--) begin
         @(posedge core_clk);
         strap <= s[0];
         rst_n <= 1'b0;
         repeat (12) @(posedge core_clk);
         rst_n <= 1'b1;
         repeat (6) @(posedge core_clk);
         #1;
         ea = model(1, 0, 2, 0, 0, s);
         eb = model(0, 1, 5, 1, 1, s);
         check("caps_a", caps_a, ea);
         check("caps_b", caps_b, eb);
         u_host.cycle(1'b0, 1'b1, PPM_CAPS_OFFSET, 16'($urandom));
         u_host.cycle(1'b1, 1'b0, PPM_CAPS_OFFSET, 16'h0000);
         #1;
         check("rdata_a", rdata_a, ea);
         check("rdata_b", rdata_b, eb);
         check("hit_a", {15'h0, hit_a}, 16'h0001);
         @(posedge core_clk);
         #1;
         check("hit_a_end", {15'h0, hit_a}, 16'h0000);
         check("rdata_a_end", rdata_a, 16'h0000);
         u_host.cycle(1'b1, 1'b0, 8'h37 + 8'($urandom_range(0, 199)), 16'h0000);
         #1;
         check("miss_hit", {15'h0, hit_b}, 16'h0000);
         check("miss_rdata", rdata_b, 16'h0000);
      end
      summarize();
   end
   initial begin
      #200000;
      num_errors++;
      summarize();
   end
endmodule

// >>> verification/ppm_host_bridge.sv
// Behavioural host bridge that issues configuration cycles.
// Assumes the bench calls cycle from one process only.
`timescale 1ns/10ps
module ppm_host_bridge (
   input  wire logic  core_clk,
   output logic       cfg_rd,
   output logic       cfg_wr,
   output logic [7:0] cfg_addr,
   output logic [15:0] cfg_wdata
);
   initial begin
      cfg_rd = 1'b0;
      cfg_wr = 1'b0;
      cfg_addr = 8'h00;
      cfg_wdata = 16'h0000;
   end
   // ==================================================================
   // One strobe cycle; address and data scramble once it is released.
   task automatic cycle(logic rd, logic wr, logic [7:0] addr, logic [15:0] wdata);
      @(posedge core_clk);
      cfg_rd <= rd;
      cfg_wr <= wr;
      cfg_addr <= addr;
      cfg_wdata <= wdata;
      @(posedge core_clk);
      cfg_rd <= 1'b0;
      cfg_wr <= 1'b0;
      cfg_addr <= ~addr;
      cfg_wdata <= ~wdata;
   endtask
endmodule
